// File: dv/io_action_asserts.sv
// concurrent checks on io_action bus handshakes and output timing
// assumes binding onto io_action, one clock domain
`timescale 1ns/100ps
module io_action_asserts
	import io_action_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
)(
	input wire logic                        i_clock,
	input wire logic                        i_rstn,
	input wire logic                        i_ce,
	input wire io_action_pkg::axil_req_type i_axi,
	input wire io_action_pkg::axil_rsp_type o_axi,
	input wire logic [CH_W-1:0]             o_channel,
	input wire logic                        o_chan_load,
	input wire io_action_pkg::mute_type     o_mute
);
	default clocking cb @(posedge i_clock); endclocking
	default disable iff (!i_rstn);
	// ----------------------------------------------------------------
	// properties
	// ----------------------------------------------------------------
	property p_b_hold; o_axi.bvalid && !i_axi.bready |=> o_axi.bvalid && $stable(o_axi.bresp);
	endproperty
	a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
	property p_r_hold; o_axi.rvalid && !i_axi.rready |=> o_axi.rvalid && $stable(o_axi.rdata);
	endproperty
	a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
	property p_ar_block; o_axi.rvalid |-> !o_axi.arready;
	endproperty
	a_ar_block: assert property (p_ar_block) else $error("arready during rvalid");
	property p_r_lat; i_ce && i_axi.arvalid && o_axi.arready |=> o_axi.rvalid;
	endproperty
	a_r_lat: assert property (p_r_lat) else $error("read answer late");
	property p_aw_block; i_ce && i_axi.awvalid && o_axi.awready |=> !o_axi.awready;
	endproperty
	a_aw_block: assert property (p_aw_block) else $error("awready after take");
	property p_b_lat; i_ce && i_axi.awvalid && o_axi.awready && i_axi.wvalid && o_axi.wready
		|-> ##[1:4] o_axi.bvalid;
	endproperty
	a_b_lat: assert property (p_b_lat) else $error("write answer late");
	property p_chan_load; $past(i_rstn) && !o_chan_load |-> $stable(o_channel);
	endproperty
	a_chan_load: assert property (p_chan_load) else $error("channel moved unflagged");
	property p_ce_freeze; !i_ce |=> $stable(o_mute) && $stable(o_channel);
	endproperty
	a_ce_freeze: assert property (p_ce_freeze) else $error("output moved while frozen");
	property p_mute_start; $rose(i_rstn) |=> (o_mute == 4'h0) [*8];
	endproperty
	a_mute_start: assert property (p_mute_start) else $error("mute after power-up");
endmodule
bind io_action io_action_asserts #(.TICK_CYCLES_P(TICK_CYCLES_P)) u_io_action_asserts (
	.i_clock(i_clock), .i_rstn(i_rstn), .i_ce(i_ce), .i_axi(i_axi), .o_axi(o_axi),
	.o_channel(o_channel), .o_chan_load(o_chan_load), .o_mute(o_mute)
);

// File: dv/io_action_tb.sv
// self-checking bench for io_action over its register bus and pins
// assumes line_source on the pins and the bound io_action_asserts
`timescale 1ns/100ps
module io_action_tb;
	import io_action_pkg::*;
	localparam int TICK_P = 10;
	localparam int WAIT_N = 4 * TICK_P + 10;
	logic         i_clock;
	logic         i_rstn;
	logic         i_ce;
	axil_req_type ax;
	axil_rsp_type rs;
	logic [2:0]   act;
	logic [2:0]   pol;
	logic [2:0]   glitch;
	logic [2:0]   line;
	logic         pv;
	logic [7:0]   pc;
	logic [7:0]   chan;
	logic [7:0]   store;
	logic         load;
	logic [7:0]   keep;
	mute_type     mute;
	int           errors;
	int           total_checks;
	io_action #(.TICK_CYCLES_P(TICK_P)) u_io_action (
		.i_clock(i_clock), .i_rstn(i_rstn), .i_ce(i_ce), .i_axi(ax), .o_axi(rs),
		.i_line(line), .i_panel_valid(pv), .i_panel_chan(pc), .i_restore_channel(keep),
		.o_channel(chan), .o_chan_load(load), .o_store_channel(store), .o_mute(mute)
	);
	line_source u_line_source (.i_act(act), .i_pol(pol), .i_glitch(glitch), .o_line(line));
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic end_of_test;
		$display("checks %0d errors %0d", total_checks, errors);
		if (errors == 0 && total_checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			errors++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic hang;
		errors++;
		end_of_test();
	endtask
	task automatic tick(input int n);
		repeat (n) @(posedge i_clock);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		int n;
		@(posedge i_clock);
		ax.awvalid <= 1'b1;
		ax.awaddr  <= a;
		ax.wvalid  <= 1'b1;
		ax.wdata   <= d;
		ax.bready  <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge i_clock);
			if (rs.awready) ax.awvalid <= 1'b0;
			if (rs.wready) ax.wvalid <= 1'b0;
			if (rs.bvalid) break;
		end
		if (n == 100) hang();
		ax.bready <= 1'b0;
		chk("bresp", 32'(rs.bresp), 32'(er));
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
		int n;
		@(posedge i_clock);
		ax.arvalid <= 1'b1;
		ax.araddr  <= a;
		ax.rready  <= 1'b1;
		for (n = 0; n < 100; n++) begin
			@(posedge i_clock);
			if (rs.arready) ax.arvalid <= 1'b0;
			if (rs.rvalid) break;
		end
		if (n == 100) hang();
		ax.rready <= 1'b0;
		chk("rdata", rs.rdata, e);
		chk("rresp", 32'(rs.rresp), 32'(er));
	endtask
	// waits for the channel (m=0) or the mute set (m=1)
	task automatic wv(input logic m, input logic [7:0] e);
		int n;
		for (n = 0; n < WAIT_N; n++) begin
			@(posedge i_clock);
			if ((m ? 8'(mute) : chan) === e) break;
		end
		if (n == WAIT_N) hang();
		chk(m ? "mute" : "chan", 32'(m ? 8'(mute) : chan), 32'(e));
		if (!m) chk("chan_load", 32'(load), 32'h1);
	endtask
	task automatic panel(input logic [7:0] c);
		@(posedge i_clock);
		pv <= 1'b1;
		pc <= c;
		@(posedge i_clock);
		pv <= 1'b0;
	endtask
	// ----------------------------------------------------------------
	// clock and sequence
	// ----------------------------------------------------------------
	initial begin
		i_clock = 1'b0;
		forever #2.5 i_clock = ~i_clock;
	end
	initial begin
		i_rstn = 1'b0;
		i_ce = 1'b1;
		ax = '0;
		ax.wstrb = 4'hf;
		act = 3'b001;
		pol = 3'b000;
		glitch = 3'b000;
		pv = 1'b0;
		pc = 8'h00;
		keep = 8'h05;
		errors = 0;
		total_checks = 0;
		tick(12);
		i_rstn <= 1'b1;
		tick(2);
		chk("chan", 32'(chan), 32'h5);
		chk("chan_load", 32'(load), 32'h1);
		rd(OFS_CTRL, 32'h00000f00, RESP_OKAY);
		rd(OFS_DB0, 32'h0000000a, RESP_OKAY);
		rd(OFS_PRESET, 32'h00000001, RESP_OKAY);
		rd(OFS_PRIO, 32'h0, RESP_OKAY);
		rd(8'h20, 32'h0, RESP_SLVERR);
		wr(8'h20, 32'h1, RESP_SLVERR);
		for (int i = 0; i < 3; i++) wr(OFS_DB0 + 8'(4 * i), 32'h2, RESP_OKAY);
		rd(OFS_DB2, 32'h2, RESP_OKAY);
		wr(OFS_PRESET, 32'h7, RESP_OKAY);
		pol <= 3'b010;
		wr(OFS_CTRL, 32'h00000b02, RESP_OKAY);
		tick(WAIT_N);
		chk("chan", 32'(chan), 32'h5);
		act[0] <= 1'b0;
		tick(WAIT_N);
		act[0] <= 1'b1;
		wv(1'b0, 8'h07);
		chk("store", 32'(store), 32'h5);
		panel(8'h03);
		tick(10);
		chk("chan", 32'(chan), 32'h7);
		act[0] <= 1'b0;
		wv(1'b0, 8'h05);
		i_ce <= 1'b0;
		tick(5);
		i_ce <= 1'b1;
		panel(8'h03);
		wv(1'b0, 8'h03);
		wr(OFS_CTRL, 32'h00000b0a, RESP_OKAY);
		panel(8'h0c);
		tick(10);
		chk("chan", 32'(chan), 32'h3);
		panel(8'h09);
		wv(1'b0, 8'h09);
		wr(OFS_CTRL, 32'h00000b12, RESP_OKAY);
		act[0] <= 1'b1;
		wv(1'b0, 8'h07);
		act[0] <= 1'b0;
		tick(WAIT_N);
		chk("chan", 32'(chan), 32'h7);
		glitch[1] <= 1'b1;
		tick(10);
		glitch[1] <= 1'b0;
		tick(WAIT_N);
		chk("mute", 32'(mute), 32'h0);
		act[1] <= 1'b1;
		wv(1'b1, 8'h03);
		act[2] <= 1'b1;
		wv(1'b1, 8'h0b);
		wr(OFS_PRIO, 32'h00000800, RESP_OKAY);
		wv(1'b1, 8'h03);
		wr(OFS_PRIO, 32'h00000824, RESP_OKAY);
		act[1] <= 1'b0;
		wv(1'b1, 8'h06);
		wr(OFS_PRIO, 32'h00000024, RESP_OKAY);
		wv(1'b1, 8'h0e);
		act[2] <= 1'b0;
		wv(1'b1, 8'h06);
		// power loss while on the preset channel, storage fed back
		wr(OFS_CTRL, 32'h00000b02, RESP_OKAY);
		panel(8'h03);
		wv(1'b0, 8'h03);
		act[0] <= 1'b1;
		wv(1'b0, 8'h07);
		chk("store", 32'(store), 32'h3);
		keep   <= store;
		i_rstn <= 1'b0;
		tick(3);
		i_rstn <= 1'b1;
		tick(2);
		chk("chan", 32'(chan), 32'h3);
		tick(3 * WAIT_N);
		chk("chan", 32'(chan), 32'h3);
		end_of_test();
	end
endmodule

// File: dv/line_source.sv
// external controller model driving the three action pins
// assumes the bench sets active state, polarity and glitches
`timescale 1ns/100ps
module line_source (
	input  wire logic [2:0] i_act,
	input  wire logic [2:0] i_pol,
	input  wire logic [2:0] i_glitch,
	output logic      [2:0] o_line
);
	// ----------------------------------------------------------------
	// pins: per-line active level, glitch flips the pin
	// ----------------------------------------------------------------
	always_comb o_line = i_act ^ i_pol ^ i_glitch;
endmodule

// File: hdl/io_action.sv
// preset channel and audio mute actions driven by debounced input lines
// assumes lines come from pins, panel requests from logic on i_clock,
// and nonvolatile storage of o_store_channel outside this block
//
// The register addresses and the AXI4-Lite interface to the registers were left to the implementer.
`timescale 1ns/100ps
module io_action
	import io_action_pkg::*;
#(
	parameter int TICK_CYCLES_P = TICK_CYCLES
)(
	input  wire logic                        i_clock,
	input  wire logic                        i_rstn,
	input  wire logic                        i_ce,
	input  wire io_action_pkg::axil_req_type i_axi,
	output io_action_pkg::axil_rsp_type      o_axi,
	input  wire logic [NLINE-1:0]            i_line,
	input  wire logic                        i_panel_valid,
	input  wire logic [CH_W-1:0]             i_panel_chan,
	input  wire logic [CH_W-1:0]             i_restore_channel,
	output logic [CH_W-1:0]                  o_channel,
	output logic                             o_chan_load,
	output logic [CH_W-1:0]                  o_store_channel,
	output io_action_pkg::mute_type          o_mute
);
	import io_action_pkg::*;

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		axil_rsp_type                 rsp;
		logic                         aw_have;
		logic                         w_have;
		logic [ADDR_W-1:0]            awaddr;
		logic [31:0]                  wdata;
		logic [3:0]                   wstrb;
		logic [11:0]                  ctrl;
		logic [NLINE-1:0][DB_W-1:0]   db;
		logic [CH_W-1:0]              preset;
		logic [11:0]                  prio;
		logic [TICK_W-1:0]            tick_cnt;
		logic                         tick;
		logic                         booted;
		logic [NLINE-1:0]             armed;
		logic [NLINE-1:0]             act_prev;
		logic                         preset_on;
		logic [CH_W-1:0]              saved;
		logic [CH_W-1:0]              chan;
		logic                         chan_load;
		logic [CH_W-1:0]              store;
		logic                         in_act;
		logic                         out_act;
		mute_type                     mute;
	} act_state_type;

	act_state_type    q;
	act_state_type    d;
	logic [NLINE-1:0] level;
	logic [NLINE-1:0] valid;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [1:0] sel_mask(input logic [1:0] sel);
		sel_mask = sel; // 1 first path, 2 second path, 3 both
	endfunction

	function automatic logic chan_ok(input logic [CH_W-1:0] c, input logic one_digit);
		chan_ok = !one_digit || (c <= ONE_DIGIT_MAX);
	endfunction

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int b = 0; b < 4; b++) begin
			if (strb[b]) begin
				r[8*b +: 8] = nw[8*b +: 8];
			end
		end
		merge = r;
	endfunction

	// ----------------------------------------------------------------
	// line debouncers
	// ----------------------------------------------------------------
	generate
		for (genvar g = 0; g < NLINE; g++) begin : g_line
			line_debounce u_deb (
				.i_clock    (i_clock),
				.i_rstn     (i_rstn),
				.i_ce       (i_ce),
				.i_tick     (q.tick),
				.i_pin      (i_line[g]),
				.i_interval (q.db[g]),
				.o_level    (level[g]),
				.o_valid    (valid[g])
			);
		end
	endgenerate

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		logic [NLINE-1:0] act;
		logic [NLINE-1:0] rise;
		logic [NLINE-1:0] fall;
		logic [31:0]      wr;
		logic [31:0]      rd;
		logic             hit;
		logic [3:0]       req;
		logic             trunk;
		d     = q;
		act   = level ^ q.ctrl[CTRL_POL_LSB +: NLINE];
		trunk = q.ctrl[CTRL_TRUNK];
		wr    = '0;
		rd    = '0;
		hit   = 1'b1;

		// millisecond tick
		d.tick = 1'b0;
		if (q.tick_cnt == TICK_W'(TICK_CYCLES_P - 1)) begin
			d.tick_cnt = '0;
			d.tick     = 1'b1;
		end else begin
			d.tick_cnt = q.tick_cnt + TICK_W'(1);
		end

		// edges count only after an inactive level has been seen
		for (int i = 0; i < NLINE; i++) begin
			if (valid[i] && !act[i]) begin
				d.armed[i] = 1'b1;
			end
		end
		d.act_prev = act & valid;
		rise = q.armed & act & ~q.act_prev;
		fall = q.armed & ~act & q.act_prev;

		// channel control
		d.chan_load = 1'b0;
		if (!q.booted) begin
			d.booted    = 1'b1;
			d.chan      = i_restore_channel;
			d.chan_load = 1'b1;
		end else if (rise[LINE_PRESET]) begin
			d.saved     = q.chan;
			d.preset_on = 1'b1;
			if (chan_ok(q.preset, q.ctrl[CTRL_ONE_DIGIT])) begin
				d.chan      = q.preset;
				d.chan_load = 1'b1;
			end
		end else if (fall[LINE_PRESET] && q.preset_on) begin
			d.preset_on = 1'b0;
			if (!trunk) begin
				d.chan      = q.saved;
				d.chan_load = 1'b1;
			end
		end else if (i_panel_valid && !q.preset_on
				&& chan_ok(i_panel_chan, q.ctrl[CTRL_ONE_DIGIT])) begin
			d.chan      = i_panel_chan;
			d.chan_load = 1'b1;
		end
		d.store = (d.preset_on && !trunk) ? d.saved : d.chan;

		// mute actions, applied the cycle after the debounced edge
		if (rise[LINE_IN]) begin
			d.in_act = 1'b1;
		end else if (fall[LINE_IN]) begin
			d.in_act = 1'b0;
		end
		if (rise[LINE_OUT]) begin
			d.out_act = 1'b1;
		end else if (fall[LINE_OUT]) begin
			d.out_act = 1'b0;
		end
		req = {sel_mask(q.ctrl[CTRL_OUT_SEL +: 2]) & {2{d.out_act}},
			sel_mask(q.ctrl[CTRL_IN_SEL +: 2]) & {2{d.in_act}}};
		// forced unmute over forced mute, line action and the prio[3:0] mute bits
		d.mute = ~q.prio[PRIO_FUNMUTE +: 4]
			& (q.prio[PRIO_FMUTE +: 4] | req | q.prio[3:0]);

		// bus write side
		if (i_axi.awvalid && q.rsp.awready) begin
			d.aw_have = 1'b1;
			d.awaddr  = i_axi.awaddr;
		end
		if (i_axi.wvalid && q.rsp.wready) begin
			d.w_have = 1'b1;
			d.wdata  = i_axi.wdata;
			d.wstrb  = i_axi.wstrb;
		end
		if (q.rsp.bvalid && i_axi.bready) begin
			d.rsp.bvalid = 1'b0;
		end
		if (q.aw_have && q.w_have && !q.rsp.bvalid) begin
			d.aw_have    = 1'b0;
			d.w_have     = 1'b0;
			d.rsp.bvalid = 1'b1;
			case (q.awaddr)
				OFS_CTRL: begin
					wr     = merge({20'h0, q.ctrl}, q.wdata, q.wstrb);
					d.ctrl = wr[11:0];
				end
				OFS_DB0: begin
					wr      = merge({24'h0, q.db[0]}, q.wdata, q.wstrb);
					d.db[0] = wr[DB_W-1:0];
				end
				OFS_DB1: begin
					wr      = merge({24'h0, q.db[1]}, q.wdata, q.wstrb);
					d.db[1] = wr[DB_W-1:0];
				end
				OFS_DB2: begin
					wr      = merge({24'h0, q.db[2]}, q.wdata, q.wstrb);
					d.db[2] = wr[DB_W-1:0];
				end
				OFS_PRESET: begin
					wr       = merge({24'h0, q.preset}, q.wdata, q.wstrb);
					d.preset = wr[CH_W-1:0];
				end
				OFS_PRIO: begin
					wr     = merge({20'h0, q.prio}, q.wdata, q.wstrb);
					d.prio = wr[11:0];
				end
				OFS_STATUS, OFS_CHAN: begin
				end
				default: begin
					hit = 1'b0;
				end
			endcase
			d.rsp.bresp = hit ? RESP_OKAY : RESP_SLVERR;
		end

		// bus read side, its own decode result
		hit = 1'b1;
		if (q.rsp.rvalid && i_axi.rready) begin
			d.rsp.rvalid = 1'b0;
		end
		if (i_axi.arvalid && q.rsp.arready) begin
			case (i_axi.araddr)
				OFS_CTRL:   rd = {20'h0, q.ctrl};
				OFS_DB0:    rd = {24'h0, q.db[0]};
				OFS_DB1:    rd = {24'h0, q.db[1]};
				OFS_DB2:    rd = {24'h0, q.db[2]};
				OFS_PRESET: rd = {24'h0, q.preset};
				OFS_PRIO:   rd = {20'h0, q.prio};
				OFS_STATUS: rd = {20'h0, q.mute, q.preset_on, q.armed, 1'b0, act & valid};
				OFS_CHAN:   rd = {16'h0, q.saved, q.chan};
				default:    hit = 1'b0;
			endcase
			d.rsp.rvalid = 1'b1;
			d.rsp.rdata  = rd;
			d.rsp.rresp  = hit ? RESP_OKAY : RESP_SLVERR;
		end

		d.rsp.awready = !d.aw_have && !d.rsp.bvalid;
		d.rsp.wready  = !d.w_have && !d.rsp.bvalid;
		d.rsp.arready = !d.rsp.rvalid;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			q             <= '0;
			q.rsp.awready <= 1'b1;
			q.rsp.wready  <= 1'b1;
			q.rsp.arready <= 1'b1;
			q.ctrl        <= CTRL_RST;
			q.db          <= {NLINE{DB_RST}};
			q.preset      <= PRESET_RST;
		end else if (i_ce) begin
			q <= d;
		end
	end

	assign o_axi           = q.rsp;
	assign o_channel       = q.chan;
	assign o_chan_load     = q.chan_load;
	assign o_store_channel = q.store;
	assign o_mute          = q.mute;
endmodule

// File: hdl/io_action_pkg.sv
// shared constants and carriers for the input-line action block
// assumes one 200 MHz clock and a 32-bit AXI4-Lite register bus
package io_action_pkg;
	// ----------------------------------------------------------------
	// widths and timing
	// ----------------------------------------------------------------
	localparam int ADDR_W        = 8;
	localparam int CH_W          = 8;
	localparam int DB_W          = 8;
	localparam int NLINE         = 3;
	localparam int TICK_W        = 18;
	localparam int CLK_PERIOD_NS = 5;
	localparam int MS_NS         = 1000000;
	// cycles per millisecond tick, rounded down
	localparam int TICK_CYCLES   = MS_NS / CLK_PERIOD_NS;

	// ----------------------------------------------------------------
	// line numbers and limits
	// ----------------------------------------------------------------
	localparam int LINE_PRESET = 0;
	localparam int LINE_IN     = 1;
	localparam int LINE_OUT    = 2;
	localparam logic [CH_W-1:0] ONE_DIGIT_MAX = 8'h09;

	// ----------------------------------------------------------------
	// register offsets
	// ----------------------------------------------------------------
	localparam logic [ADDR_W-1:0] OFS_CTRL   = 8'h00;
	localparam logic [ADDR_W-1:0] OFS_DB0    = 8'h04;
	localparam logic [ADDR_W-1:0] OFS_DB1    = 8'h08;
	localparam logic [ADDR_W-1:0] OFS_DB2    = 8'h0c;
	localparam logic [ADDR_W-1:0] OFS_PRESET = 8'h10;
	localparam logic [ADDR_W-1:0] OFS_PRIO   = 8'h14;
	localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h18;
	localparam logic [ADDR_W-1:0] OFS_CHAN   = 8'h1c;

	// ----------------------------------------------------------------
	// field positions and reset values
	// ----------------------------------------------------------------
	localparam int CTRL_POL_LSB   = 0;
	localparam int CTRL_ONE_DIGIT = 3;
	localparam int CTRL_TRUNK     = 4;
	localparam int CTRL_IN_SEL    = 8;
	localparam int CTRL_OUT_SEL   = 10;
	localparam int PRIO_FMUTE     = 4;
	localparam int PRIO_FUNMUTE   = 8;
	localparam logic [11:0]     CTRL_RST   = 12'hf00;
	localparam logic [DB_W-1:0] DB_RST     = 8'h0a;
	localparam logic [CH_W-1:0] PRESET_RST = 8'h01;
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// ----------------------------------------------------------------
	// carriers
	// ----------------------------------------------------------------
	typedef struct packed {
		logic              awvalid;
		logic [ADDR_W-1:0] awaddr;
		logic              wvalid;
		logic [31:0]       wdata;
		logic [3:0]        wstrb;
		logic              bready;
		logic              arvalid;
		logic [ADDR_W-1:0] araddr;
		logic              rready;
	} axil_req_type;

	typedef struct packed {
		logic        awready;
		logic        wready;
		logic        bvalid;
		logic [1:0]  bresp;
		logic        arready;
		logic        rvalid;
		logic [31:0] rdata;
		logic [1:0]  rresp;
	} axil_rsp_type;

	// bit order aux, speaker, tap, mic
	typedef struct packed {
		logic aux;
		logic spk;
		logic tap;
		logic mic;
	} mute_type;
endpackage

// File: hdl/line_debounce.sv
// two-flop synchroniser and debouncer for one input line
// assumes a one-cycle millisecond tick from the parent
`timescale 1ns/100ps
module line_debounce
	import io_action_pkg::*;
(
	input  wire logic            i_clock,
	input  wire logic            i_rstn,
	input  wire logic            i_ce,
	input  wire logic            i_tick,
	input  wire logic            i_pin,
	input  wire logic [DB_W-1:0] i_interval,
	output logic                 o_level,
	output logic                 o_valid
);
	typedef struct packed {
		logic          s1;
		logic          s2;
		logic          cand;
		logic          level;
		logic          valid;
		logic [DB_W:0] cnt;
	} deb_state_type;

	deb_state_type q;
	deb_state_type d;

	always_comb begin
		d    = q;
		d.s1 = i_pin;
		d.s2 = q.s1;
		if (q.s2 != q.cand) begin
			d.cand = q.s2;
			d.cnt  = '0;
		end else if (i_tick && q.cnt <= {1'b0, i_interval}) begin
			d.cnt = q.cnt + (DB_W+1)'(1);
		end
		// stable for more than the full interval of ticks
		if (q.s2 == q.cand && q.cnt > {1'b0, i_interval}) begin
			d.level = q.cand;
			d.valid = 1'b1;
		end
	end

	always_ff @(posedge i_clock or negedge i_rstn) begin
		if (!i_rstn) begin
			q <= '0;
		end else if (i_ce) begin
			q <= d;
		end
	end

	assign o_level = q.level;
	assign o_valid = q.valid;
endmodule
